// ---- bench/bhf_bus_hold_properties.sv ----
// Purpose: hold handshake and fetch flag checks
// Assumes: enable bit is set only after reset
// Notes: bound to the block
`timescale 1ns/100ps
module bhf_bus_hold_properties
  import bhf_pkg::*;
(
  // Clock and inputs
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [P2_W-1:0] window_select_control,
  input wire logic [P2_W-1:0] port2_pin_in,
  input wire bhf_cyc_t cyc_req,
  // Outputs
  input wire logic cyc_grant,
  input wire logic bus_released,
  input wire logic [P2_W-1:0] port2_pin_oe,
  input wire logic [P2_W-1:0] port2_pin_out,
  input wire logic hold_req_seen,
  input wire bhf_p2cfg_t p2cfg,
  input wire logic instruction_fetch_flag,
  input wire logic hold_acknowledge_n,
  input wire logic bus_request_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Short terms; clk_en low freezes state, so timed checks except a_bus_request_n_kept carry it
  wire en7 = window_select_control[HOLD_EN_BIT];
  wire hreq = !port2_pin_in[PIN_HOLD_REQ];
  wire ack = !hold_acknowledge_n;
  wire brq = !bus_request_n;
  wire ext = cyc_req.valid && cyc_req.external;
  a_ack_on_time:
    assert property (clk_en && en7 && hreq && !cyc_grant && !bus_released |=> ack)
      else $error("ack late");
  a_ack_free:
    assert property (ack |-> bus_released && !cyc_grant) else $error("ack with bus busy");
  a_ack_exit:
    assert property (ack && clk_en |=> hold_acknowledge_n == !($past(en7) && $past(hreq)))
      else $error("ack exit wrong");
  a_pins_locked:
    assert property ($past(en7) && $past(clk_en) |->
      port2_pin_oe[PIN_HOLD_ACK] && port2_pin_oe[PIN_BUS_REQ] && !port2_pin_oe[PIN_HOLD_REQ])
      else $error("pin not locked");
  a_pins_follow:
    assert property ($past(en7) && $past(clk_en) |->
      port2_pin_out[PIN_HOLD_ACK] == hold_acknowledge_n &&
      port2_pin_out[PIN_BUS_REQ] == bus_request_n)
      else $error("locked pin value wrong");
  a_pin_mux:
    assert property ($past(clk_en) && !$past(en7) |->
      port2_pin_out == $past(p2cfg.data) && port2_pin_oe == ~$past(p2cfg.dir))
      else $error("port pins not from config");
  a_seen_delay:
    assert property ($past(clk_en) |-> hold_req_seen == $past(en7 && hreq))
      else $error("request seen wrong");
  a_bus_request_n_pending:
    assert property (clk_en && en7 && ack && hreq && ext |=> brq) else $error("bus_request_n late");
  a_bus_request_n_order:
    assert property (brq |-> ack) else $error("bus_request_n before ack");
  a_bus_request_n_kept:
    assert property (brq && en7 && hreq |=> brq) else $error("bus_request_n dropped");
  a_fetch_flag:
    assert property (instruction_fetch_flag == (cyc_grant && ext && cyc_req.instr))
      else $error("fetch flag wrong");
  // Main scenarios reached
  cover property (ack);
  cover property (brq);
  cover property (instruction_fetch_flag);
  cover property (ack && brq);
endmodule : bhf_bus_hold_properties

bind bhf_bus_hold bhf_bus_hold_properties u_props (.*);

// ---- bench/bhf_bus_hold_tb_top.sv ----
// Purpose: directed bench for the bus hold block
// Assumes: clk_en tied high
// Notes: outside master modelled apart
`timescale 1ns/100ps
module bhf_bus_hold_tb_top
  import bhf_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic cfg_wr = 1'b0;
  logic cyc_done = 1'b0;
  logic want_bus = 1'b0;
  logic [P2_W-1:0] window_select_control = 8'h00;
  bhf_p2cfg_t cfg_wdata = '0;
  bhf_cyc_t cyc_req = '0;
  bhf_p2cfg_t p2cfg;
  logic hold_req_n, cyc_grant, bus_released, instruction_fetch_flag;
  logic hold_acknowledge_n, bus_request_n;
  int miscompares = 0;
  int tests_run = 0;
  // Block and outside master
  bhf_bus_hold DUT (.*, .port2_pin_in({2'h3, hold_req_n, 5'h1f}), .port2_pin_out(),
    .port2_pin_oe(), .hold_req_seen());
  bhf_master_model u_master (.ref_clk(ref_clk), .want_bus(want_bus), .hold_req_n(hold_req_n));
  // Clock and watchdog
  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    #4000;
    miscompares++;
    test_done();
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  // Config write under a given enable; locked pins must keep old bits
  task automatic cfg(input logic [7:0] en, input logic [23:0] wd, input logic [23:0] exp);
    @(posedge ref_clk) window_select_control <= en;
    @(posedge ref_clk) {cfg_wr, cfg_wdata} <= {1'b1, wd};
    @(posedge ref_clk) cfg_wr <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(p2cfg, exp);
  endtask : cfg
  // One core cycle; flag expected only for external fetches
  task automatic cyc(input bhf_cyc_t c);
    @(posedge ref_clk) cyc_req <= c;
    repeat (3) @(negedge ref_clk);
    chk(instruction_fetch_flag, c.external & c.instr);
    @(posedge ref_clk) cyc_done <= c.external;
    @(posedge ref_clk) {cyc_req, cyc_done} <= '0;
    @(negedge ref_clk) chk(instruction_fetch_flag, 1'b0);
  endtask : cyc
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(negedge ref_clk) chk(p2cfg, {PORT2_FUNC_RST, PORT2_DIR_RST, PORT2_DATA_RST});
    cfg(8'h80, 24'hff0000, 24'h976868);
    cfg(8'h00, 24'hff0000, 24'hff0000);
    @(posedge ref_clk) window_select_control <= 8'h80;
    cyc(3'b111);
    cyc(3'b110);
    cyc(3'b101);
    // Hold asked mid fetch waits for its end, then a data cycle stays pending
    @(posedge ref_clk) {cyc_req, want_bus} <= {3'b111, 1'b1};
    repeat (4) @(negedge ref_clk);
    chk(hold_acknowledge_n, 1'b1);
    @(posedge ref_clk) cyc_done <= 1'b1;
    @(posedge ref_clk) {cyc_req, cyc_done} <= {3'b110, 1'b0};
    @(negedge ref_clk) chk({hold_acknowledge_n, bus_request_n}, 2'b01);
    repeat (4) @(negedge ref_clk);
    chk({hold_acknowledge_n, bus_request_n, bus_released, cyc_grant}, 4'h2);
    @(posedge ref_clk) want_bus <= 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({hold_acknowledge_n, bus_request_n, cyc_grant}, 3'b111);
    @(posedge ref_clk) cyc_done <= 1'b1;
    @(posedge ref_clk) {cyc_req, cyc_done} <= '0;
    // Without the enable bit a request is not granted
    @(posedge ref_clk) {window_select_control, want_bus} <= {8'h00, 1'b1};
    repeat (5) @(negedge ref_clk);
    chk(hold_acknowledge_n, 1'b1);
    test_done();
  end
endmodule : bhf_bus_hold_tb_top

// ---- bench/bhf_master_model.sv ----
// Purpose: outside master asking for the shared bus
// Assumes: bench says when the bus is wanted
// Notes: request is driven high, not floated, when idle
`timescale 1ns/100ps
module bhf_master_model (
  // Bench control
  input wire logic ref_clk,
  input wire logic want_bus,
  // Request pin
  output logic hold_req_n = 1'b1
);
  // Request held low for as long as the bus is wanted
  always @(posedge ref_clk) hold_req_n <= !want_bus;
endmodule : bhf_master_model

// ---- design/bhf_bus_hold.sv ----
// Purpose: bus hold handshake, port 2 pin locking and fetch status output
// Assumes: all inputs synchronous to ref_clk; core issues one bus cycle at a time
// Notes: a pin with direction bit 0 drives; func_sel is only stored, the hold enable bit selects the special function
//   A new hold request wins over a core cycle first seen in the same idle cycle.
//   Writes to locked pins are dropped for good; software repeats them after disable.
//   Bus request counts only cycles still waiting, never the one ending this cycle.
//   clk_en low freezes every register, so each handshake answer stretches with it.
`timescale 1ns/100ps
module bhf_bus_hold
  import bhf_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Control
  input wire logic [P2_W-1:0] window_select_control,
  input wire logic cfg_wr,
  input wire bhf_p2cfg_t cfg_wdata,
  // Core bus cycles
  input wire bhf_cyc_t cyc_req,
  input wire logic cyc_done,
  output logic cyc_grant,
  output logic bus_released,
  // Port 2 pins
  input wire logic [P2_W-1:0] port2_pin_in,
  output logic [P2_W-1:0] port2_pin_out,
  output logic [P2_W-1:0] port2_pin_oe,
  output logic hold_req_seen,
  // Status
  output logic instruction_fetch_flag,
  output logic hold_acknowledge_n,
  output logic bus_request_n,
  output bhf_p2cfg_t p2cfg
);
  // Sequencer state and decodes
  bhf_state_t state;
  bhf_state_t next_state;
  logic hold_en;
  logic hold_req;
  logic ext_pending;
  logic cyc_ending;
  logic cyc_pending;
  logic bus_request_n_latched;
  logic next_bus_request_n;
  logic next_flag;
  // Pin muxing
  logic [P2_W-1:0] lock_mask;
  logic [P2_W-1:0] next_out;
  logic [P2_W-1:0] next_oe;
  logic [P2_W-1:0] drv_dir;
  // Stored configuration fields, one flop bank each
  logic [P2_W-1:0] func_sel_q;
  logic [P2_W-1:0] dir_q;
  logic [P2_W-1:0] data_q;

  // Decodes of enable and request pin
  assign hold_en = window_select_control[HOLD_EN_BIT];
  assign hold_req = hold_en & ~port2_pin_in[PIN_HOLD_REQ];
  assign ext_pending = cyc_req.valid & cyc_req.external;

  // The request is still held on the edge that finishes it; that cycle is not pending
  assign cyc_ending = (state == BHF_CYCLE) & cyc_done;
  assign cyc_pending = ext_pending & ~cyc_ending;

  // Locked pins keep old configuration bits while hold is enabled
  assign lock_mask = hold_en ? ((8'h01 << PIN_BUS_REQ) | (8'h01 << PIN_HOLD_REQ)
                                | (8'h01 << PIN_HOLD_ACK)) : 8'h00;

  // Handshake sequencing; a running cycle ends before grant
  always_comb begin
    next_state = state;
    unique case (state)
      BHF_IDLE: begin
        if (hold_req) begin
          next_state = BHF_HOLD;
        end else if (ext_pending) begin
          next_state = BHF_CYCLE;
        end
      end
      BHF_CYCLE: begin
        if (cyc_done) begin
          next_state = hold_req ? BHF_HOLD : BHF_IDLE;
        end
      end
      BHF_HOLD: begin
        if (!hold_req) begin
          next_state = BHF_IDLE;
        end
      end
    endcase
  end

  // Bus request: only inside hold, sticky until request lifts
  assign next_bus_request_n = (next_state == BHF_HOLD) && (bus_request_n_latched || cyc_pending);

  // Fetch flag: only an external instruction cycle raises it, for its whole length
  assign next_flag = (next_state == BHF_CYCLE) & cyc_req.instr;

  // Pin muxing: locked hold pins override port settings
  assign drv_dir = ~p2cfg.dir;
  always_comb begin
    next_out = p2cfg.data;
    next_oe = drv_dir;
    if (hold_en) begin
      next_out[PIN_HOLD_ACK] = next_state != BHF_HOLD;
      next_oe[PIN_HOLD_ACK] = 1'b1;
      next_out[PIN_BUS_REQ] = ~next_bus_request_n;
      next_oe[PIN_BUS_REQ] = 1'b1;
      next_out[PIN_HOLD_REQ] = 1'b0;
      next_oe[PIN_HOLD_REQ] = 1'b0;
    end
  end

  // Sequencer state and the sticky bus request
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= BHF_IDLE;
      bus_request_n_latched <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      bus_request_n_latched <= next_bus_request_n;
    end
  end

  // Handshake outputs, registered so the pins never glitch
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_acknowledge_n <= 1'b1;
      bus_request_n <= 1'b1;
      bus_released <= 1'b0;
      hold_req_seen <= 1'b0;
    end else if (clk_en) begin
      hold_acknowledge_n <= next_state != BHF_HOLD;
      bus_request_n <= ~next_bus_request_n;
      bus_released <= next_state == BHF_HOLD;
      hold_req_seen <= hold_req;
    end
  end

  // Core cycle grant and fetch flag, both dropping on the edge after cyc_done
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_grant <= 1'b0;
      instruction_fetch_flag <= 1'b0;
    end else if (clk_en) begin
      cyc_grant <= next_state == BHF_CYCLE;
      instruction_fetch_flag <= next_flag;
    end
  end

  // Port 2 pin drivers, one cycle behind the configuration
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port2_pin_out <= PORT2_DATA_RST;
      port2_pin_oe <= 8'h00;
    end else if (clk_en) begin
      port2_pin_out <= next_out;
      port2_pin_oe <= next_oe;
    end
  end

  // Configuration store; writes to locked pins are dropped, not deferred
  bhf_cfg_field #(.W(P2_W), .RST_VAL(PORT2_FUNC_RST)) u_func_sel (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .wr(cfg_wr),
    .keep_mask(lock_mask),
    .wdata(cfg_wdata.func_sel),
    .q(func_sel_q)
  );
  bhf_cfg_field #(.W(P2_W), .RST_VAL(PORT2_DIR_RST)) u_dir (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .wr(cfg_wr),
    .keep_mask(lock_mask),
    .wdata(cfg_wdata.dir),
    .q(dir_q)
  );
  bhf_cfg_field #(.W(P2_W), .RST_VAL(PORT2_DATA_RST)) u_data (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .wr(cfg_wr),
    .keep_mask(lock_mask),
    .wdata(cfg_wdata.data),
    .q(data_q)
  );

  // Present the stored fields as one configuration word
  assign p2cfg = {func_sel_q, dir_q, data_q};
endmodule : bhf_bus_hold

// One port 2 configuration field; bits under keep_mask hold their old value on a write
module bhf_cfg_field
  import bhf_pkg::*;
#(
  parameter int unsigned W = P2_W,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Write side
  input wire logic wr,
  input wire logic [W-1:0] keep_mask,
  input wire logic [W-1:0] wdata,
  // Stored field
  output logic [W-1:0] q
);
  logic [W-1:0] next_q;

  // Merge keeps locked bits; a dropped write is not replayed after unlock
  assign next_q = (wdata & ~keep_mask) | (q & keep_mask);

  // Field storage, frozen with the enable
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST_VAL;
    end else if (clk_en && wr) begin
      q <= next_q;
    end
  end
endmodule : bhf_cfg_field

// ---- design/bhf_pkg.sv ----
// Purpose: shared constants and types for the bus hold and fetch status block
// Assumes: single clock domain, port configuration presented as plain ports
// Notes: pin indices are positions within the eight-bit port 2
package bhf_pkg;
  localparam int unsigned P2_W = 8;
  localparam int unsigned PIN_BUS_REQ = 3;
  localparam int unsigned PIN_HOLD_REQ = 5;
  localparam int unsigned PIN_HOLD_ACK = 6;
  localparam int unsigned HOLD_EN_BIT = 7;
  localparam logic [P2_W-1:0] PORT2_FUNC_RST = 8'h00;
  localparam logic [P2_W-1:0] PORT2_DIR_RST = 8'hff;
  localparam logic [P2_W-1:0] PORT2_DATA_RST = 8'hff;

  // Port 2 configuration as software writes it
  typedef struct packed {
    logic [P2_W-1:0] func_sel;
    logic [P2_W-1:0] dir;
    logic [P2_W-1:0] data;
  } bhf_p2cfg_t;

  // Bus cycle request from the core
  typedef struct packed {
    logic valid;
    logic external;
    logic instr;
  } bhf_cyc_t;

  typedef enum logic [1:0] {
    BHF_IDLE,
    BHF_CYCLE,
    BHF_HOLD
  } bhf_state_t;
endpackage : bhf_pkg
